// ---- common/irq_ctrl_pkg.sv ----
// Register map, fields, reset values and timing counts of the interrupt controller.
package irq_ctrl_pkg;
    // Byte addresses on the Wishbone bus.
    localparam logic [7:0] ADDR_CONTROL   = 8'h00;
    localparam logic [7:0] ADDR_PFLAG_A   = 8'h04;
    localparam logic [7:0] ADDR_PFLAG_B   = 8'h08;
    localparam logic [7:0] ADDR_PEN_A     = 8'h0C;
    localparam logic [7:0] ADDR_PEN_B     = 8'h10;
    localparam logic [7:0] ADDR_OPTION    = 8'h14;
    localparam logic [7:0] ADDR_CORE      = 8'h18;
    localparam logic [7:0] ADDR_STATUS    = 8'h1C;

    // Control register fields.
    localparam int CTL_GEN    = 7;
    localparam int CTL_PEN    = 6;
    localparam int CTL_TWE    = 5;
    localparam int CTL_XPE    = 4;
    localparam int CTL_PCE    = 3;
    localparam int CTL_TWF    = 2;
    localparam int CTL_XPF    = 1;
    localparam int CTL_PCF    = 0;

    // Option register field and reset value.
    localparam int          OPT_EDGE      = 6;
    localparam logic [7:0]  OPTION_RESET  = 8'hFF;
    localparam logic [7:0]  CONTROL_RESET = 8'h00;

    // Core command register bits (write one to act).
    localparam int CORE_RET    = 0;
    localparam int CORE_SLEEP  = 1;

    // Status register fields.
    localparam int ST_SLEEP  = 0;
    localparam int ST_ACTIVE = 1;
    localparam int ST_REQ    = 2;

    // Instruction cycle is four clocks: phases Q1..Q4.
    localparam int          NUM_PHASES   = 4;
    localparam logic [1:0]  PHASE_Q1     = 2'h0;
    localparam logic [1:0]  PHASE_Q2     = 2'h1;
    localparam logic [1:0]  PHASE_Q4     = 2'h3;
    // Instruction cycles from sampled flag to vectoring.
    localparam int          VECTOR_DELAY_CYC = 3;
    localparam logic [12:0] IRQ_VECTOR   = 13'h0004;

    // Timer 0 rollover values.
    localparam logic [7:0]  TMR_MAX      = 8'hFF;
    localparam logic [7:0]  TMR_ZERO     = 8'h00;
endpackage : irq_ctrl_pkg

// ---- common/flag_if.sv ----
// Interface carrying one source's set pulse, software clear and resulting flag.
`timescale 1ns/1ps
interface flag_if;
    logic set_p;
    logic clr_p;
    logic wr_p;
    logic wr_val;
    logic flag;
    modport owner (input set_p, input clr_p, input wr_p, input wr_val, output flag);
    modport user  (output set_p, output clr_p, output wr_p, output wr_val, input flag);
endinterface : flag_if

// ---- rtl/irq_flag.sv ----
// One sticky interrupt request flag where a hardware set wins over a software write.
`timescale 1ns/1ps
module irq_flag (
    input  wire logic clk_i,
    input  wire logic rst_i,
    input  wire logic keep_i,
    flag_if.owner     f
);
    logic flag_r;

    always_ff @(posedge clk_i) begin
        if (rst_i && !keep_i) begin
            flag_r <= 1'b0;
        end else if (f.set_p) begin
            flag_r <= 1'b1;
        end else if (f.wr_p) begin
            flag_r <= f.wr_val;
        end else if (f.clr_p) begin
            flag_r <= 1'b0;
        end
    end

    assign f.flag = flag_r;
endmodule : irq_flag

// ---- rtl/irq_edge.sv ----
// Edge detector that raises a one-cycle pulse on a selected edge of a sampled level.
`timescale 1ns/1ps
module irq_edge #(
    parameter int WIDTH = 1
) (
    input  wire logic             clk_i,
    input  wire logic             rst_i,
    input  wire logic [WIDTH-1:0] level_i,
    input  wire logic             rise_i,
    input  wire logic             any_i,
    output logic                  pulse_o
);
    logic [WIDTH-1:0] prev_r;

    initial begin
        if (WIDTH < 1) $error("irq_edge needs WIDTH of at least one");
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            prev_r <= level_i;
        end else begin
            prev_r <= level_i;
        end
    end

    always_comb begin
        if (any_i) begin
            pulse_o = |(prev_r ^ level_i);
        end else if (rise_i) begin
            pulse_o = |(~prev_r & level_i);
        end else begin
            pulse_o = |(prev_r & ~level_i);
        end
    end
endmodule : irq_edge

// ---- rtl/core_interrupt_controller.sv ----
// Interrupt controller of an 8-bit core: flags, masks, wake-up and vectoring over Wishbone.
//
// Summary of operation
// - Up to twelve sources, each with a request flag and enable bit.
// - A source event sets its flag regardless of its enable or global enable.
// - Global enable bit 7 of control allows unmasked sources; clear blocks all.
// - Global enable plus enabled set flag takes the interrupt three instruction cycles after the Q1 sample.
// - Every reset clears the global enable.
// - Taking an interrupt clears global enable, pushes return address, loads 0004h.
// - Return-from-interrupt leaves the routine and sets global enable again.
// - Peripheral flags and enables in two register pairs, gated by peripheral enable.
// - Software clears the flag before re-enabling, else it retriggers immediately.
// - Pin and port-change latency is three or four instruction cycles.
// - External flag set in Q4 to Q1, sampled once per cycle in Q1.
// - External pin edge triggered; option bit 6 picks rising or falling.
// - A valid external edge sets the external flag, control bit 1.
// - Control bit 4 masks the external pin interrupt.
// - Enabled pin event wakes from sleep; vector only if global enable set.
// - Timer 0 FFh to 00h rollover sets control bit 2; bit 5 masks it.
// - Any change on upper four port pins sets control bit 0; own enable.
// - A port change coinciding with a Q2 read still sets the flag.
// - Entry saves only the return address; software saves working registers.
// - Reset zeroes control except the port-change flag, which is kept.
`timescale 1ns/1ps
module core_interrupt_controller #(
    parameter int NUM_PERIPH_A = 8,
    parameter int NUM_PERIPH_B = 1
) (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // Wishbone slave.
    input  wire logic        cyc_i,
    input  wire logic        stb_i,
    input  wire logic        we_i,
    input  wire logic [7:0]  adr_i,
    input  wire logic [3:0]  sel_i,
    input  wire logic [31:0] dat_i,
    output logic      [31:0] dat_o,
    output logic             ack_o,
    // Event sources.
    input  wire logic        ext_irq_pin_i,
    input  wire logic [3:0]  upper_pin_group_i,
    input  wire logic [7:0]  timer0_count_i,
    input  wire logic [7:0]  periph_a_set_i,
    input  wire logic [7:0]  periph_b_set_i,
    // Core sequencer interface.
    input  wire logic [12:0] return_pc_i,
    output logic             vector_o,
    output logic [12:0]      vector_pc_o,
    output logic [12:0]      push_pc_o,
    output logic             wake_o,
    output logic             sleeping_o
);
    // ------------------------------------------------------------------
    // Parameter check
    // ------------------------------------------------------------------
    initial begin
        if (NUM_PERIPH_A < 0 || NUM_PERIPH_A > 8 || NUM_PERIPH_B < 0 || NUM_PERIPH_B > 8
            || 3 + NUM_PERIPH_A + NUM_PERIPH_B > 12) begin
            $error("core_interrupt_controller supports at most twelve sources");
        end
    end

    // ------------------------------------------------------------------
    // Phase counter and bus decode
    // ------------------------------------------------------------------
    logic [1:0]  phase_r;
    logic        req_go;
    logic        wr_ctl;
    logic        wr_pfa;
    logic        wr_pfb;
    logic [7:0]  wdat;
    logic        core_wr;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            phase_r <= irq_ctrl_pkg::PHASE_Q1;
        end else begin
            phase_r <= phase_r + 2'h1;
        end
    end

    assign req_go  = cyc_i && stb_i && !ack_o;
    assign wdat    = sel_i[0] ? dat_i[7:0] : 8'h00;
    assign wr_ctl  = req_go && we_i && sel_i[0] && adr_i == irq_ctrl_pkg::ADDR_CONTROL;
    assign wr_pfa  = req_go && we_i && sel_i[0] && adr_i == irq_ctrl_pkg::ADDR_PFLAG_A;
    assign wr_pfb  = req_go && we_i && sel_i[0] && adr_i == irq_ctrl_pkg::ADDR_PFLAG_B;
    assign core_wr = req_go && we_i && sel_i[0] && adr_i == irq_ctrl_pkg::ADDR_CORE;

    // ------------------------------------------------------------------
    // Enable registers
    // ------------------------------------------------------------------
    logic        gen_r;
    logic [6:3]  ctl_en_r;
    logic [7:0]  pen_a_r;
    logic [7:0]  pen_b_r;
    logic [7:0]  option_r;
    logic        take;
    logic        ret_go;

    assign ret_go = core_wr && dat_i[irq_ctrl_pkg::CORE_RET];

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            gen_r <= 1'b0;
        end else if (take) begin
            gen_r <= 1'b0;
        end else if (ret_go) begin
            gen_r <= 1'b1;
        end else if (wr_ctl) begin
            gen_r <= wdat[irq_ctrl_pkg::CTL_GEN];
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctl_en_r <= irq_ctrl_pkg::CONTROL_RESET[6:3];
            pen_a_r  <= 8'h00;
            pen_b_r  <= 8'h00;
            option_r <= irq_ctrl_pkg::OPTION_RESET;
        end else if (req_go && we_i && sel_i[0]) begin
            if (adr_i == irq_ctrl_pkg::ADDR_CONTROL) begin
                ctl_en_r <= wdat[6:3];
            end else if (adr_i == irq_ctrl_pkg::ADDR_PEN_A) begin
                pen_a_r <= wdat;
            end else if (adr_i == irq_ctrl_pkg::ADDR_PEN_B) begin
                pen_b_r <= wdat;
            end else if (adr_i == irq_ctrl_pkg::ADDR_OPTION) begin
                option_r <= wdat;
            end
        end
    end

    // ------------------------------------------------------------------
    // Source detection
    // ------------------------------------------------------------------
    logic       ext_edge;
    logic       pin_chg;
    logic [7:0] tmr_prev_r;
    logic       tmr_wrap;
    logic       ext_pend_r;

    irq_edge #(.WIDTH(1)) u_ext_edge (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .level_i (ext_irq_pin_i),
        .rise_i  (option_r[irq_ctrl_pkg::OPT_EDGE]),
        .any_i   (1'b0),
        .pulse_o (ext_edge)
    );

    // Compares against every sample, so a change during a port read is never lost.
    irq_edge #(.WIDTH(4)) u_pin_chg (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .level_i (upper_pin_group_i),
        .rise_i  (1'b0),
        .any_i   (1'b1),
        .pulse_o (pin_chg)
    );

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            tmr_prev_r <= irq_ctrl_pkg::TMR_ZERO;
        end else begin
            tmr_prev_r <= timer0_count_i;
        end
    end

    assign tmr_wrap = tmr_prev_r == irq_ctrl_pkg::TMR_MAX && timer0_count_i == irq_ctrl_pkg::TMR_ZERO;

    // An edge seen in Q2 or Q3 is held and posted to the flag in Q4, so an edge only sets the flag in Q4..Q1.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ext_pend_r <= 1'b0;
        end else if (phase_r == irq_ctrl_pkg::PHASE_Q4 || phase_r == irq_ctrl_pkg::PHASE_Q1) begin
            ext_pend_r <= 1'b0;
        end else if (ext_edge) begin
            ext_pend_r <= 1'b1;
        end
    end

    // ------------------------------------------------------------------
    // Flags
    // ------------------------------------------------------------------
    localparam int NUM_FLAGS = 19;
    flag_if fl [NUM_FLAGS] ();
    logic [NUM_FLAGS-1:0] set_v;
    logic [NUM_FLAGS-1:0] wr_v;
    logic [NUM_FLAGS-1:0] val_v;
    logic [NUM_FLAGS-1:0] keep_v;
    logic [NUM_FLAGS-1:0] flag_v;
    logic                 ext_in_window;

    assign ext_in_window = phase_r == irq_ctrl_pkg::PHASE_Q4 || phase_r == irq_ctrl_pkg::PHASE_Q1;

    always_comb begin
        set_v  = '0;
        wr_v   = '0;
        val_v  = '0;
        keep_v = '0;
        set_v[irq_ctrl_pkg::CTL_PCF] = pin_chg;
        set_v[irq_ctrl_pkg::CTL_XPF] = ext_in_window && (ext_edge || ext_pend_r);
        set_v[irq_ctrl_pkg::CTL_TWF] = tmr_wrap;
        set_v[10:3]                   = periph_a_set_i;
        set_v[18:11]                  = periph_b_set_i;
        wr_v[2:0]                     = {3{wr_ctl}};
        wr_v[10:3]                    = {8{wr_pfa}};
        wr_v[18:11]                   = {8{wr_pfb}};
        val_v[2:0]                    = wdat[2:0];
        val_v[10:3]                   = wdat;
        val_v[18:11]                  = wdat;
        keep_v[irq_ctrl_pkg::CTL_PCF] = 1'b1;
    end

    for (genvar i = 0; i < NUM_FLAGS; i++) begin : g_flag
        assign fl[i].set_p  = set_v[i];
        assign fl[i].clr_p  = 1'b0;
        assign fl[i].wr_p   = wr_v[i];
        assign fl[i].wr_val = val_v[i];
        assign flag_v[i]    = fl[i].flag;
        irq_flag u_flag (
            .clk_i  (clk_i),
            .rst_i  (rst_i),
            .keep_i (keep_v[i]),
            .f      (fl[i])
        );
    end

    // ------------------------------------------------------------------
    // Request and vectoring
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        ST_RUN   = 2'b00,
        ST_WAIT  = 2'b01,
        ST_SLEEP = 2'b10
    } state_t;

    state_t      state_r;
    state_t      state_nxt;
    logic        core_req;
    logic        q1_req_r;
    logic [1:0]  delay_r;
    logic [7:0]  pmask_a;
    logic [7:0]  pmask_b;
    logic        wake_evt;

    assign pmask_a = NUM_PERIPH_A == 0 ? 8'h00 : 8'hFF >> (8 - NUM_PERIPH_A);
    assign pmask_b = NUM_PERIPH_B == 0 ? 8'h00 : 8'hFF >> (8 - NUM_PERIPH_B);

    assign core_req = (flag_v[irq_ctrl_pkg::CTL_PCF] && ctl_en_r[irq_ctrl_pkg::CTL_PCE])
        || (flag_v[irq_ctrl_pkg::CTL_XPF] && ctl_en_r[irq_ctrl_pkg::CTL_XPE])
        || (flag_v[irq_ctrl_pkg::CTL_TWF] && ctl_en_r[irq_ctrl_pkg::CTL_TWE])
        || (ctl_en_r[irq_ctrl_pkg::CTL_PEN]
            && |((flag_v[10:3] & pen_a_r & pmask_a) | (flag_v[18:11] & pen_b_r & pmask_b)));

    assign wake_evt = core_req;
    assign take     = state_r == ST_WAIT && delay_r == 2'h0 && phase_r == irq_ctrl_pkg::PHASE_Q4 && gen_r;

    // Request is latched once per instruction cycle at Q1.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            q1_req_r <= 1'b0;
        end else if (phase_r == irq_ctrl_pkg::PHASE_Q1) begin
            q1_req_r <= core_req && gen_r;
        end
    end

    always_comb begin
        state_nxt = state_r;
        case (state_r)
            ST_RUN: begin
                if (core_wr && dat_i[irq_ctrl_pkg::CORE_SLEEP]) begin
                    state_nxt = ST_SLEEP;
                end else if (q1_req_r && phase_r == irq_ctrl_pkg::PHASE_Q2) begin
                    state_nxt = ST_WAIT;
                end
            end
            ST_WAIT: begin
                if (!gen_r || take) begin
                    state_nxt = ST_RUN;
                end
            end
            ST_SLEEP: begin
                if (wake_evt) begin
                    state_nxt = ST_RUN;
                end
            end
            default: begin
                state_nxt = ST_RUN;
            end
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_r <= ST_RUN;
        end else begin
            state_r <= state_nxt;
        end
    end

    // Extra instruction cycles keep latency at three to four regardless of instruction length.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            delay_r <= 2'h0;
        end else if (state_r != ST_WAIT) begin
            delay_r <= 2'(irq_ctrl_pkg::VECTOR_DELAY_CYC - 1);
        end else if (phase_r == irq_ctrl_pkg::PHASE_Q4 && delay_r != 2'h0) begin
            delay_r <= delay_r - 2'h1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            vector_o    <= 1'b0;
            vector_pc_o <= 13'h0000;
            push_pc_o   <= 13'h0000;
            wake_o      <= 1'b0;
            sleeping_o  <= 1'b0;
        end else begin
            vector_o    <= take;
            vector_pc_o <= irq_ctrl_pkg::IRQ_VECTOR;
            push_pc_o   <= take ? return_pc_i : push_pc_o;
            wake_o      <= state_r == ST_SLEEP && wake_evt;
            sleeping_o  <= state_nxt == ST_SLEEP;
        end
    end

    // ------------------------------------------------------------------
    // Read data and acknowledge
    // ------------------------------------------------------------------
    logic [7:0] ctl_rd;
    logic [7:0] rd;

    assign ctl_rd = {gen_r, ctl_en_r, flag_v[2:0]};

    always_comb begin
        if (adr_i == irq_ctrl_pkg::ADDR_CONTROL) begin
            rd = ctl_rd;
        end else if (adr_i == irq_ctrl_pkg::ADDR_PFLAG_A) begin
            rd = flag_v[10:3];
        end else if (adr_i == irq_ctrl_pkg::ADDR_PFLAG_B) begin
            rd = flag_v[18:11];
        end else if (adr_i == irq_ctrl_pkg::ADDR_PEN_A) begin
            rd = pen_a_r;
        end else if (adr_i == irq_ctrl_pkg::ADDR_PEN_B) begin
            rd = pen_b_r;
        end else if (adr_i == irq_ctrl_pkg::ADDR_OPTION) begin
            rd = option_r;
        end else if (adr_i == irq_ctrl_pkg::ADDR_STATUS) begin
            rd = {5'h00, core_req, state_r == ST_WAIT, state_r == ST_SLEEP};
        end else begin
            rd = 8'h00;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_o <= 1'b0;
            dat_o <= 32'h00000000;
        end else begin
            ack_o <= req_go;
            dat_o <= req_go ? {24'h000000, rd} : 32'h00000000;
        end
    end
endmodule : core_interrupt_controller

// ---- tb/irq_ctrl_assertions.sv ----
// Port checker bound into the interrupt controller.
`timescale 1ns/1ps
module irq_ctrl_assertions (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        vector_o,
    input  wire logic [12:0] vector_pc_o,
    input  wire logic [12:0] push_pc_o,
    input  wire logic [12:0] return_pc_i,
    input  wire logic        wake_o,
    input  wire logic        sleeping_o
);
    // ----------------------------------------------------------------
    // Properties
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    // Quiet time after every vector.
    sequence s_quiet;
        !vector_o [*8];
    endsequence

    property p_reset;
        disable iff (1'h0) rst_i |=> !vector_o && !wake_o && !sleeping_o;
    endproperty
    a_reset: assert property (p_reset) else $error("outputs active after reset");
    property p_vec_pc;
        vector_o |-> vector_pc_o == irq_ctrl_pkg::IRQ_VECTOR;
    endproperty
    a_vec_pc: assert property (p_vec_pc) else $error("wrong vector address");
    property p_push;
        vector_o && $stable(return_pc_i) |-> push_pc_o == return_pc_i;
    endproperty
    a_push: assert property (p_push) else $error("wrong return address");
    property p_vec_gap;
        vector_o |=> s_quiet;
    endproperty
    a_vec_gap: assert property (p_vec_gap) else $error("vector repeated too soon");
    property p_wake_src;
        wake_o |-> $past(sleeping_o);
    endproperty
    a_wake_src: assert property (p_wake_src) else $error("wake while awake");
    property p_wake_pulse;
        wake_o |=> !wake_o;
    endproperty
    a_wake_pulse: assert property (p_wake_pulse) else $error("wake longer than a cycle");
    property p_sleep_exit;
        $fell(sleeping_o) |-> wake_o || $past(wake_o) || $past(rst_i);
    endproperty
    a_sleep_exit: assert property (p_sleep_exit) else $error("sleep left without wake");
    property p_vec_awake;
        vector_o |-> !sleeping_o;
    endproperty
    a_vec_awake: assert property (p_vec_awake) else $error("vector while asleep");
endmodule : irq_ctrl_assertions

bind core_interrupt_controller irq_ctrl_assertions u_chk (
    .clk_i(clk_i), .rst_i(rst_i), .vector_o(vector_o), .vector_pc_o(vector_pc_o),
    .push_pc_o(push_pc_o), .return_pc_i(return_pc_i), .wake_o(wake_o), .sleeping_o(sleeping_o)
);

// ---- tb/core_seq_model.sv ----
// Core sequencer model with an eight-entry return stack.
`timescale 1ns/1ps
module core_seq_model #(
    parameter logic [12:0] START_PC = 13'h0123
) (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        vector_i,
    input  wire logic        ret_i,
    input  wire logic [12:0] vector_pc_i,
    input  wire logic [12:0] push_pc_i,
    output logic      [12:0] pc_o,
    output logic      [12:0] top_o,
    output logic      [3:0]  depth_o
);
    logic [12:0] stack_r [8];

    assign top_o = stack_r[3'(depth_o - 4'h1)];

    // Only the return address is stacked; working registers stay with software.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pc_o    <= START_PC;
            depth_o <= 4'h0;
        end else if (vector_i) begin
            stack_r[depth_o[2:0]] <= push_pc_i;
            depth_o               <= depth_o + 4'h1;
            pc_o                  <= vector_pc_i;
        end else if (ret_i) begin
            pc_o    <= top_o;
            depth_o <= depth_o - 4'h1;
        end
    end
endmodule : core_seq_model

// ---- tb/core_interrupt_controller_test.sv ----
// Testbench of the interrupt controller and a sequencer model.
`timescale 1ns/1ps
module core_interrupt_controller_test;
    localparam logic [7:0] A_CTL = irq_ctrl_pkg::ADDR_CONTROL;
    localparam logic [7:0] GEN   = 8'h80;
    localparam logic [7:0] XPE   = 8'h10;
    localparam logic [7:0] XPF   = 8'h02;
    localparam logic [7:0] PEIE  = 8'h01 << irq_ctrl_pkg::CTL_PEN;
    logic        clk_i = 1'h0;
    logic        rst_i = 1'h1;
    logic        cyc_i = 1'h0, stb_i = 1'h0, we_i = 1'h0, pin = 1'h0, ret_p = 1'h0;
    logic [7:0]  adr_i = 8'h00, tmr = 8'h00, pa = 8'h00, pb = 8'h00;
    logic [3:0]  sel_i = 4'h0, grp = 4'h0;
    logic [31:0] dat_i = 32'h0;
    logic [31:0] dat_o;
    logic [31:0] rd;
    logic        ack_o, vector_o, wake_o, sleeping_o;
    logic [12:0] pc, vpc, ppc, top;
    logic [3:0]  depth;
    int          mismatches = 0;
    int          comparisons = 0;
    int          cycles = 0, n;

    initial forever #2 clk_i = ~clk_i;

    core_interrupt_controller #(.NUM_PERIPH_A(8), .NUM_PERIPH_B(1)) u_dut (
        .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
        .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .ext_irq_pin_i(pin),
        .upper_pin_group_i(grp), .timer0_count_i(tmr), .periph_a_set_i(pa), .periph_b_set_i(pb),
        .return_pc_i(pc), .vector_o(vector_o), .vector_pc_o(vpc), .push_pc_o(ppc),
        .wake_o(wake_o), .sleeping_o(sleeping_o));
    core_seq_model u_core (.clk_i(clk_i), .rst_i(rst_i), .vector_i(vector_o), .ret_i(ret_p),
        .vector_pc_i(vpc), .push_pc_i(ppc), .pc_o(pc), .top_o(top), .depth_o(depth));

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    task automatic test_done;
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : test_done

    always @(posedge clk_i) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            mismatches++;
            test_done();
        end
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            mismatches++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    // Classic cycle; data is taken where ack is sampled.
    task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_i);
        cyc_i <= 1'h1;
        stb_i <= 1'h1;
        we_i  <= w;
        adr_i <= a;
        sel_i <= 4'hF;
        dat_i <= {24'h0, d};
        do @(posedge clk_i);
        while (ack_o !== 1'h1);
        rd = dat_o;
        cyc_i <= 1'h0;
        stb_i <= 1'h0;
        we_i  <= 1'h0;
    endtask : wb

    task automatic rdc(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m);
        wb(1'h0, a, 8'h00);
        check(rd & {24'hFFFFFF, m}, {24'h0, e});
    endtask : rdc

    task automatic ret;
        wb(1'h1, irq_ctrl_pkg::ADDR_CORE, 8'h01);
        ret_p <= 1'h1;
        @(posedge clk_i);
        ret_p <= 1'h0;
    endtask : ret

    task automatic no_vec(input int k);
        repeat (k) begin
            @(posedge clk_i);
            check(vector_o, 1'h0);
        end
    endtask : no_vec

    task automatic wait_vec;
        n = 0;
        while (vector_o !== 1'h1 && n < 40) begin
            @(posedge clk_i);
            n++;
        end
    endtask : wait_vec

    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task automatic t_reset;
        rdc(A_CTL, 8'h00, 8'hFE);
        rdc(irq_ctrl_pkg::ADDR_OPTION, irq_ctrl_pkg::OPTION_RESET, 8'hFF);
        wb(1'h1, 8'h40, 8'hFF);
        rdc(8'h40, 8'h00, 8'hFF);
        wb(1'h1, A_CTL, GEN | 8'h01);
        @(posedge clk_i);
        rst_i <= 1'h1;
        repeat (4) @(posedge clk_i);
        rst_i <= 1'h0;
        rdc(A_CTL, 8'h01, 8'hFF);
        wb(1'h1, A_CTL, 8'h00);
    endtask : t_reset

    task automatic t_flags;
        wb(1'h1, irq_ctrl_pkg::ADDR_OPTION, 8'hBF);
        pin <= 1'h1;
        repeat (8) @(posedge clk_i);
        rdc(A_CTL, 8'h00, XPF);
        pin <= 1'h0;
        repeat (8) @(posedge clk_i);
        rdc(A_CTL, XPF, XPF);
        tmr <= 8'hFF;
        @(posedge clk_i);
        tmr <= 8'h00;
        grp <= 4'h5;
        pa  <= 8'h80;
        pb  <= 8'h01;
        @(posedge clk_i);
        pa <= 8'h00;
        pb <= 8'h00;
        repeat (8) @(posedge clk_i);
        rdc(A_CTL, 8'h07, 8'hFF);
        rdc(irq_ctrl_pkg::ADDR_PFLAG_A, 8'h80, 8'hFF);
        rdc(irq_ctrl_pkg::ADDR_PFLAG_B, 8'h01, 8'hFF);
        wb(1'h1, irq_ctrl_pkg::ADDR_OPTION, 8'hFF);
        wb(1'h1, A_CTL, 8'h00);
    endtask : t_flags

    task automatic t_take;
        wb(1'h1, A_CTL, GEN | XPE);
        no_vec(24);
        @(posedge clk_i);
        pin <= 1'h1;
        wait_vec();
        // Three to four instruction cycles, plus the registered vector.
        check(n >= 12 && n <= 17, 1'h1);
        @(posedge clk_i);
        check(pc, irq_ctrl_pkg::IRQ_VECTOR);
        check(top, 13'h0123);
        rdc(A_CTL, XPE | XPF, 8'hFF);
        ret();
        wait_vec();
        check(n < 40, 1'h1);
        @(posedge clk_i);
        check(top, 13'h0123);
        wb(1'h1, A_CTL, XPE);
        ret();
        rdc(A_CTL, GEN | XPE, 8'hFF);
        no_vec(24);
    endtask : t_take

    task automatic t_mask;
        wb(1'h1, A_CTL, GEN);
        pin <= 1'h0;
        @(posedge clk_i);
        pin <= 1'h1;
        no_vec(24);
        rdc(A_CTL, GEN | XPF, 8'hFF);
        wb(1'h1, A_CTL, XPE | XPF);
        no_vec(24);
        wb(1'h1, irq_ctrl_pkg::ADDR_PEN_A, 8'h01);
        wb(1'h1, A_CTL, GEN);
        pa <= 8'h01;
        @(posedge clk_i);
        pa <= 8'h00;
        no_vec(24);
        wb(1'h1, A_CTL, GEN | PEIE);
        wait_vec();
        check(n < 40, 1'h1);
        wb(1'h1, irq_ctrl_pkg::ADDR_PFLAG_A, 8'h00);
        ret();
        wb(1'h1, A_CTL, 8'h00);
        pin <= 1'h0;
    endtask : t_mask

    task automatic t_sleep;
        wb(1'h1, A_CTL, XPE);
        wb(1'h1, irq_ctrl_pkg::ADDR_CORE, 8'h02);
        @(posedge clk_i);
        check(sleeping_o, 1'h1);
        pin <= 1'h1;
        n = 0;
        while (wake_o !== 1'h1 && n < 40) begin
            @(posedge clk_i);
            n++;
        end
        check(n < 40, 1'h1);
        no_vec(24);
        check(sleeping_o, 1'h0);
        rdc(A_CTL, XPE | XPF, 8'hFF);
    endtask : t_sleep

    // Software clears the global enable and re-reads it until it stays clear.
    task automatic t_gen_off;
        wb(1'h1, A_CTL, GEN);
        n = 0;
        do begin
            wb(1'h1, A_CTL, 8'h00);
            wb(1'h0, A_CTL, 8'h00);
            n++;
        end while (rd[7] !== 1'h0 && n < 8);
        check(rd[7], 1'h0);
    endtask : t_gen_off

    initial begin
        repeat (20) @(posedge clk_i);
        rst_i <= 1'h0;
        t_reset();
        t_flags();
        t_take();
        t_mask();
        t_sleep();
        t_gen_off();
        test_done();
    end
endmodule : core_interrupt_controller_test
